// ==== spreading_pkg.sv ====
package spreading_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_CODE_SELECT = 8'h03;
  localparam logic [7:0] IDX_SPREAD_CFG  = 8'h04;
  localparam logic [7:0] IDX_CODE_BASE   = 8'h08;
  localparam logic [7:0] IDX_CODE_LAST   = 8'h0f;
  localparam logic [7:0] IDX_MODE_STATUS = 8'h20;

  // Field positions
  localparam int CFG_SAMPLE_BIT = 0;
  localparam int CFG_RATE_BIT   = 1;
  localparam int CFG_WIDTH_BIT  = 2;
  localparam int SEL_CODE_BIT   = 5;

  // Values after reset
  localparam logic [2:0] CFG_RESET  = 3'h0;
  localparam logic       SEL_RESET  = 1'b0;
  localparam logic [7:0] CODE_RESET = 8'h00;

  // Code geometry
  localparam int         CODE_BYTES  = 8;
  localparam logic [6:0] CHIPS_LONG  = 7'h40;
  localparam logic [6:0] CHIPS_SHORT = 7'h20;

  // Raw throughput in bits per second for each rate
  localparam int RATE_NORMAL_BPS = 32000;
  localparam int RATE_DOUBLE_BPS = 62500;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_e;

endpackage

// ==== code_store.sv ====
`timescale 1ns/1ps
module code_store
  import spreading_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        we_i,
  input  wire logic [2:0]  wr_idx_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic [2:0]  rd_idx_i,
  output logic      [7:0]  rd_data_o,
  output logic      [63:0] code_o
);

  logic [7:0] mem_q [CODE_BYTES];

  for (genvar i = 0; i < CODE_BYTES; i++) begin : g_byte
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mem_q[i] <= CODE_RESET;
      end else if (we_i && wr_idx_i == 3'(i)) begin
        mem_q[i] <= wr_data_i;
      end
    end
    assign code_o[8*i +: 8] = mem_q[i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem_q[rd_idx_i];
    end
  end

endmodule

// ==== spreading_rate_config.sv ====
`timescale 1ns/1ps
module spreading_rate_config
  import spreading_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        chip_tick_i,
  input  wire logic        tx_bit_i,
  input  wire logic        tx_valid_i,
  input  wire logic        tx_last_i,
  output logic             tx_ready_o,
  output logic             tx_chip_o,
  output logic             tx_active_o,
  input  wire logic        rx_restart_i,
  input  wire logic        rx_chip_i,
  input  wire logic        rx_chip_valid_i,
  output logic             rx_valid_o,
  output logic      [1:0]  rx_bits_o,
  output logic             rx_two_bits_o,
  output logic             rx_code_id_o,
  output logic             short_code_o,
  output logic             double_rate_o,
  output logic             oversample_12x_o
);

  logic [2:0]  cfg_q;
  logic        sel_q;
  logic        pend_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  idx;
  logic        req;
  logic        wr_now;
  logic        mem_hit;
  logic [7:0]  mem_rd;
  logic [63:0] code;
  logic [7:0]  status;

  assign idx     = wb_adr_i[9:2];
  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_now  = req && pend_q && !ack_q && wb_we_i && wb_sel_i[0];
  assign mem_hit = idx >= IDX_CODE_BASE && idx <= IDX_CODE_LAST;

  // Mode decode
  logic short_c;
  logic double_c;
  logic os12_c;
  logic dual_c;
  logic [6:0] chips;

  assign short_c  = cfg_q[CFG_WIDTH_BIT];
  assign double_c = short_c && cfg_q[CFG_RATE_BIT];
  // 12x sampling decides on the first correlator only and costs the second code
  assign os12_c   = short_c && !double_c && cfg_q[CFG_SAMPLE_BIT];
  assign dual_c   = short_c && !double_c && !os12_c;
  assign chips    = short_c ? CHIPS_SHORT : CHIPS_LONG;

  // Bus slave: ack two edges after the request so read data leave a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      pend_q <= req && !pend_q && !ack_q;
      ack_q  <= req && pend_q && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && pend_q && !ack_q) begin
      dat_q <= 32'h0000_0000;
      if (idx == IDX_SPREAD_CFG) begin
        dat_q[2:0] <= cfg_q;
      end else if (idx == IDX_CODE_SELECT) begin
        dat_q[SEL_CODE_BIT] <= sel_q;
      end else if (idx == IDX_MODE_STATUS) begin
        dat_q[7:0] <= status;
      end else if (mem_hit) begin
        dat_q[7:0] <= mem_rd;
      end
    end
  end

  // Upper bits are dropped; software keeps them zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RESET;
    end else if (wr_now && idx == IDX_SPREAD_CFG) begin
      cfg_q <= wb_dat_i[2:0];
    end
  end

  // Consistency with the short code is left to software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= SEL_RESET;
    end else if (wr_now && idx == IDX_CODE_SELECT) begin
      sel_q <= wb_dat_i[SEL_CODE_BIT];
    end
  end

  code_store i_code_store (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (wr_now && mem_hit),
    .wr_idx_i  (idx[2:0]),
    .wr_data_i (wb_dat_i[7:0]),
    .rd_idx_i  (idx[2:0]),
    .rd_data_o (mem_rd),
    .code_o    (code)
  );

  // Transmit spreader
  tx_state_e  tx_state_q;
  logic [5:0] tx_idx_q;
  logic       tx_half_q;
  logic       tx_val_q;
  logic       pair_have_q;
  logic       pair_bit_q;
  logic       tx_take;
  logic       tx_start;
  logic [5:0] tx_pos;

  assign tx_take  = tx_state_q == TX_IDLE && tx_valid_i && tx_ready_o;
  // Double rate waits for a partner bit unless the frame ends here
  assign tx_start = tx_take && (!double_c || pair_have_q || tx_last_i);
  assign tx_pos   = tx_idx_q + {tx_half_q, 5'h00};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_have_q <= 1'b0;
      pair_bit_q  <= 1'b0;
    end else if (tx_take) begin
      pair_have_q <= double_c && !pair_have_q && !tx_last_i;
      pair_bit_q  <= tx_bit_i;
    end
  end

  // Mode changes mid-symbol are not guarded; reconfigure while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_q <= TX_IDLE;
      tx_idx_q   <= 6'h00;
      tx_half_q  <= 1'b0;
      tx_val_q   <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_ready_o <= !tx_start;
          if (tx_start) begin
            tx_state_q <= TX_SEND;
            tx_idx_q   <= 6'h00;
            if (!double_c) begin
              tx_val_q  <= tx_bit_i;
              tx_half_q <= short_c && sel_q;
            end else if (pair_have_q) begin
              tx_val_q  <= pair_bit_q;
              tx_half_q <= tx_bit_i;
            end else begin
              tx_val_q  <= tx_bit_i;
              tx_half_q <= 1'b0;
            end
          end
        end
        TX_SEND: begin
          tx_ready_o <= 1'b0;
          if (chip_tick_i) begin
            tx_idx_q <= tx_idx_q + 6'h01;
            if ({1'b0, tx_idx_q} == chips - 7'h01) begin
              tx_state_q <= TX_IDLE;
              tx_ready_o <= 1'b1;
            end
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
          tx_ready_o <= 1'b0;
        end
      endcase
    end
  end

  // A one bit sends the code as stored, a zero sends it inverted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_chip_o   <= 1'b0;
      tx_active_o <= 1'b0;
    end else begin
      tx_active_o <= tx_state_q == TX_SEND;
      if (tx_state_q == TX_SEND && chip_tick_i) begin
        tx_chip_o <= ~(code[tx_pos] ^ tx_val_q);
      end
    end
  end

  // Receive correlator against both halves of the stored code
  logic [5:0] rx_idx_q;
  logic [6:0] agree_a_q;
  logic [6:0] agree_b_q;
  logic [6:0] agree_a;
  logic [6:0] agree_b;
  logic [6:0] dev_a;
  logic [6:0] dev_b;
  logic [6:0] mid;
  logic       pick_b;
  logic       rx_end;

  assign mid     = {1'b0, chips[6:1]};
  assign agree_a = agree_a_q + {6'h00, rx_chip_i == code[{1'b0, rx_idx_q[4:0]} | {rx_idx_q[5], 5'h00}]};
  assign agree_b = agree_b_q + {6'h00, rx_chip_i == code[{1'b1, rx_idx_q[4:0]}]};
  assign dev_a   = agree_a >= mid ? agree_a - mid : mid - agree_a;
  assign dev_b   = agree_b >= mid ? agree_b - mid : mid - agree_b;
  assign pick_b  = (double_c || dual_c) && dev_b > dev_a;
  assign rx_end  = rx_chip_valid_i && {1'b0, rx_idx_q} == chips - 7'h01;

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_restart_i) begin
      rx_idx_q  <= 6'h00;
      agree_a_q <= 7'h00;
      agree_b_q <= 7'h00;
    end else if (rx_end) begin
      rx_idx_q  <= 6'h00;
      agree_a_q <= 7'h00;
      agree_b_q <= 7'h00;
    end else if (rx_chip_valid_i) begin
      rx_idx_q  <= rx_idx_q + 6'h01;
      agree_a_q <= agree_a;
      agree_b_q <= agree_b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_o    <= 1'b0;
      rx_bits_o     <= 2'h0;
      rx_two_bits_o <= 1'b0;
      rx_code_id_o  <= 1'b0;
    end else begin
      rx_valid_o <= rx_end && !rx_restart_i;
      if (rx_end && !rx_restart_i) begin
        rx_bits_o[0]  <= (pick_b ? agree_b : agree_a) >= mid;
        rx_bits_o[1]  <= double_c && pick_b;
        rx_two_bits_o <= double_c;
        rx_code_id_o  <= dual_c && pick_b;
      end
    end
  end

  // Mode status and outputs to the baseband; chip rate sets the throughput
  assign status = {2'b00, pair_have_q, tx_state_q == TX_SEND, dual_c, os12_c, double_c, short_c};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_code_o     <= 1'b0;
      double_rate_o    <= 1'b0;
      oversample_12x_o <= 1'b0;
    end else begin
      short_code_o     <= short_c;
      double_rate_o    <= double_c;
      oversample_12x_o <= os12_c;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

endmodule

// ==== spreading_rate_config_properties.sv ====
`timescale 1ns/1ps
module spreading_rate_config_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       chip_tick_i,
  input wire logic       tx_valid_i,
  input wire logic       tx_ready_o,
  input wire logic       rx_valid_o,
  input wire logic [1:0] rx_bits_o,
  input wire logic       rx_two_bits_o,
  input wire logic       short_code_o,
  input wire logic       double_rate_o,
  input wire logic       oversample_12x_o
);
  logic [6:0] tick_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Ticks since the symbol started
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_ready_o) tick_q <= 7'h00;
    else if (chip_tick_i) tick_q <= tick_q + 7'h01;
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_delay_a: assert property ($rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##2 wb_ack_o)
    else $error("ack not two cycles after request");
  double_short_a: assert property (double_rate_o |-> short_code_o)
    else $error("double rate with long codes");
  oversample_mode_a: assert property (oversample_12x_o |-> short_code_o && !double_rate_o)
    else $error("oversampling in wrong mode");
  two_bits_a: assert property (rx_valid_o && rx_two_bits_o |-> double_rate_o)
    else $error("two bits outside double rate");
  one_bit_a: assert property (rx_valid_o && !double_rate_o |-> !rx_two_bits_o && !rx_bits_o[1])
    else $error("normal rate gave two bits");
  rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("decision pulse too long");
  ready_drop_a: assert property (tx_valid_i && tx_ready_o && !double_rate_o |=> !tx_ready_o)
    else $error("ready kept after bit");
  symbol_len_a: assert property ($rose(tx_ready_o) && tick_q != 7'h00 |->
    tick_q == (short_code_o ? 7'h20 : 7'h40))
    else $error("symbol length wrong");
  cover property (rx_valid_o && rx_two_bits_o);
  cover property (double_rate_o && $rose(tx_ready_o));
  cover property (oversample_12x_o);
endmodule
bind spreading_rate_config spreading_rate_config_properties i_props (
  .clk_i            (clk_i),
  .rst_i            (rst_i),
  .wb_cyc_i         (wb_cyc_i),
  .wb_stb_i         (wb_stb_i),
  .wb_ack_o         (wb_ack_o),
  .chip_tick_i      (chip_tick_i),
  .tx_valid_i       (tx_valid_i),
  .tx_ready_o       (tx_ready_o),
  .rx_valid_o       (rx_valid_o),
  .rx_bits_o        (rx_bits_o),
  .rx_two_bits_o    (rx_two_bits_o),
  .short_code_o     (short_code_o),
  .double_rate_o    (double_rate_o),
  .oversample_12x_o (oversample_12x_o)
);

// ==== host_model.sv ====
`timescale 1ns/1ps
module host_model
  import spreading_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o = 1'b0,
  output logic             we_o = 1'b0,
  output logic [9:0]       adr_o = 10'h000,
  output logic [31:0]      wdat_o = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o  <= 1'b1;
    we_o   <= w;
    adr_o  <= {i, 2'b00};
    wdat_o <= {24'h0, (i == IDX_SPREAD_CFG) ? (d & 8'h07) : d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    q = rdat_i[7:0];
    ok = (ack_i === 1'b1);
    cyc_o <= 1'b0;
  endtask
endmodule

// ==== spreading_rate_config_tb.sv ====
`timescale 1ns/1ps
module spreading_rate_config_tb
  import spreading_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1, chip_tick_i = 1'b0, tx_bit_i = 1'b0;
  logic        tx_valid_i = 1'b0, tx_last_i = 1'b0, rx_restart_i = 1'b0;
  logic        rx_chip_i = 1'b0, rx_chip_valid_i = 1'b0;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_ready_o, tx_chip_o;
  logic        tx_active_o, rx_valid_o, rx_two_bits_o, rx_code_id_o;
  logic        short_code_o, double_rate_o, oversample_12x_o;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [9:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0]  rx_bits_o;
  int          mismatches = 0;
  int          compares = 0;
  assign wb_stb_i = wb_cyc_i;
  initial forever #12.5 clk_i = ~clk_i;
  spreading_rate_config i_spreading_rate_config (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_sel_i         (wb_sel_i),
    .wb_dat_i         (wb_dat_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .chip_tick_i      (chip_tick_i),
    .tx_bit_i         (tx_bit_i),
    .tx_valid_i       (tx_valid_i),
    .tx_last_i        (tx_last_i),
    .tx_ready_o       (tx_ready_o),
    .tx_chip_o        (tx_chip_o),
    .tx_active_o      (tx_active_o),
    .rx_restart_i     (rx_restart_i),
    .rx_chip_i        (rx_chip_i),
    .rx_chip_valid_i  (rx_chip_valid_i),
    .rx_valid_o       (rx_valid_o),
    .rx_bits_o        (rx_bits_o),
    .rx_two_bits_o    (rx_two_bits_o),
    .rx_code_id_o     (rx_code_id_o),
    .short_code_o     (short_code_o),
    .double_rate_o    (double_rate_o),
    .oversample_12x_o (oversample_12x_o)
  );
  host_model i_host_model (.clk_i(clk_i), .ack_i(wb_ack_o), .rdat_i(wb_dat_o),
    .cyc_o(wb_cyc_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .wdat_o(wb_dat_i));
  task automatic test_done;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang;
    mismatches++;
    $display("mismatch at %0t: wait timed out", $time);
    test_done;
  endtask
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    logic ok;
    i_host_model.xfer(w, i, d, q, ok);
    if (!ok) hang;
  endtask
  task automatic send(input logic b, input logic hold, input logic last,
                      input logic [7:0] nexp, input logic c0);
    int n;
    logic [7:0] cnt;
    logic c;
    logic a;
    n = 0;
    cnt = 8'h00;
    c = 1'b0;
    a = 1'b0;
    tx_bit_i   <= b;
    tx_last_i  <= last;
    tx_valid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (tx_ready_o !== 1'b1 && n < 50);
    tx_valid_i <= 1'b0;
    @(posedge clk_i);
    chk({7'h0, tx_ready_o}, {7'h0, hold});
    if (hold) return;
    while (tx_ready_o !== 1'b1 && cnt < 8'h50) begin
      chip_tick_i <= 1'b1;
      @(posedge clk_i);
      chip_tick_i <= 1'b0;
      cnt++;
      @(posedge clk_i);
      if (cnt == 8'h01) begin
        c = tx_chip_o;
        a = tx_active_o;
      end
    end
    if (n >= 50 || cnt >= 8'h50) hang;
    chk(cnt, nexp);
    chk({7'h0, c}, {7'h0, c0});
    // Busy flag lags the state by one edge, so look one edge later
    @(posedge clk_i);
    chk({6'h0, a, tx_active_o}, 8'h02);
  endtask
  task automatic rcv(input logic [7:0] len, input logic [7:0] off, input logic [3:0] e);
    int n;
    n = 0;
    rx_restart_i <= 1'b1;
    @(posedge clk_i);
    rx_restart_i <= 1'b0;
    for (int i = 0; i < len; i++) begin
      rx_chip_i       <= (i + off >= 32) && (i + off < 40);
      rx_chip_valid_i <= 1'b1;
      @(posedge clk_i);
      rx_chip_valid_i <= 1'b0;
      @(posedge clk_i);
    end
    while (rx_valid_o !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4) hang;
    chk({4'h0, rx_code_id_o, rx_two_bits_o, rx_bits_o}, {4'h0, e});
  endtask
  task automatic t_regs;
    logic [7:0] q;
    acc(1'b0, IDX_SPREAD_CFG, 8'h00, q);
    chk(q, {5'h0, CFG_RESET});
    acc(1'b0, IDX_MODE_STATUS, 8'h00, q);
    chk(q, 8'h00);
    acc(1'b1, 8'h11, 8'h5a, q);
    acc(1'b0, 8'h11, 8'h00, q);
    chk(q, 8'h00);
    // Write without the low byte lane must leave the setting alone
    wb_sel_i <= 4'h0;
    acc(1'b1, IDX_SPREAD_CFG, 8'h07, q);
    wb_sel_i <= 4'h1;
    acc(1'b0, IDX_SPREAD_CFG, 8'h00, q);
    chk(q, {5'h0, CFG_RESET});
  endtask
  task automatic t_modes;
    logic [7:0] q;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, IDX_SPREAD_CFG, 8'(c), q);
      acc(1'b0, IDX_SPREAD_CFG, 8'h00, q);
      chk(q, 8'(c));
      chk({5'h0, short_code_o, double_rate_o, oversample_12x_o},
          {5'h0, c[2], c[2] & c[1], c[2] & ~c[1] & c[0]});
    end
  endtask
  task automatic t_tx;
    logic [7:0] q;
    acc(1'b1, IDX_CODE_BASE + 8'h04, 8'hff, q);
    acc(1'b0, IDX_CODE_BASE + 8'h04, 8'h00, q);
    chk(q, 8'hff);
    acc(1'b1, IDX_CODE_SELECT, 8'h00, q);
    acc(1'b1, IDX_SPREAD_CFG, 8'h04, q);
    send(1'b0, 1'b0, 1'b0, 8'h20, 1'b1);
    // Code select picks the upper half for single-rate short codes
    acc(1'b1, IDX_CODE_SELECT, 8'h20, q);
    acc(1'b0, IDX_CODE_SELECT, 8'h00, q);
    chk(q, 8'h20);
    send(1'b0, 1'b0, 1'b0, 8'h20, 1'b0);
    acc(1'b1, IDX_CODE_SELECT, 8'h00, q);
    acc(1'b1, IDX_SPREAD_CFG, 8'h06, q);
    send(1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
    acc(1'b0, IDX_MODE_STATUS, 8'h00, q);
    chk(q, 8'h23);
    send(1'b1, 1'b0, 1'b0, 8'h20, 1'b1);
    send(1'b1, 1'b0, 1'b1, 8'h20, 1'b0);
    acc(1'b1, IDX_SPREAD_CFG, 8'h02, q);
    send(1'b1, 1'b0, 1'b0, 8'h40, 1'b0);
  endtask
  task automatic t_rx;
    logic [7:0] q;
    acc(1'b1, IDX_SPREAD_CFG, 8'h06, q);
    rcv(8'h20, 8'h20, 4'h7);
    acc(1'b1, IDX_SPREAD_CFG, 8'h04, q);
    rcv(8'h20, 8'h20, 4'h9);
    acc(1'b1, IDX_SPREAD_CFG, 8'h00, q);
    rcv(8'h40, 8'h00, 4'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_modes;
    t_tx;
    t_rx;
    test_done;
  end
endmodule
